// *** rtl/imcp_pkg.sv ***
// Package of constants and types shared by the two-wire mode control port.
package imcp_pkg;
	// Fixed upper six bits of the 7-bit bus address; the low bit comes from the select pin.
	localparam logic [5:0] DEV_ADDR_HI = 6'h23;
	// Register index window and the value at which the index wraps.
	localparam logic [7:0] IDX_FIRST = 8'h40;
	localparam logic [7:0] IDX_LAST = 8'h49;
	localparam logic [7:0] IDX_WRAP = 8'h4a;
	localparam int REG_COUNT = 10;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	// Register offsets.
	localparam logic [7:0] OFS_POWER_AND_RESET_CONTROL = 8'h40;
	localparam logic [7:0] OFS_PLAYBACK_LEVEL_FIRST = 8'h41;
	localparam logic [7:0] OFS_PLAYBACK_LEVEL_SECOND = 8'h42;
	localparam logic [7:0] OFS_PLAYBACK_INTERFACE_SETUP = 8'h43;
	localparam logic [7:0] OFS_PLAYBACK_RATE_PHASE_MUTE = 8'h44;
	localparam logic [7:0] OFS_PLAYBACK_FILTER_ZERO_FLAGS = 8'h45;
	localparam logic [7:0] OFS_RECORD_LEVEL_FIRST = 8'h46;
	localparam logic [7:0] OFS_RECORD_LEVEL_SECOND = 8'h47;
	localparam logic [7:0] OFS_RECORD_INTERFACE_SETUP = 8'h48;
	localparam logic [7:0] OFS_RECORD_FILTER_PHASE_MUTE = 8'h49;
	// Bit positions in the power and reset control register.
	localparam int BIT_REGISTER_RESET = 7;
	localparam int BIT_RESYNC_RESET = 6;
	localparam int BIT_RECORD_POWER_SAVE = 5;
	localparam int BIT_PLAYBACK_POWER_SAVE = 4;
	localparam int BIT_OUTPUT_SINGLE_ENDED = 0;
	// Reset values: both reset bits idle high, both paths in power save, differential output.
	localparam logic [7:0] RST_POWER_AND_RESET_CONTROL = 8'hf0;
	// Playback level 0 dB is the all-ones code.
	localparam logic [7:0] RST_PLAYBACK_LEVEL = 8'hff;
	// Record level spans +20 dB to -100 dB from the all-ones code down, so 0 dB sits 40 steps below it.
	localparam logic [7:0] RST_RECORD_LEVEL = 8'hd7;
	// Clock select, slave mode, I2S format, low oversampling, normal phase, unmuted, sharp rolloff.
	localparam logic [7:0] RST_PLAYBACK_INTERFACE_SETUP = 8'h00;
	localparam logic [7:0] RST_PLAYBACK_RATE_PHASE_MUTE = 8'h00;
	localparam logic [7:0] RST_PLAYBACK_FILTER_ZERO_FLAGS = 8'h00;
	localparam logic [7:0] RST_RECORD_INTERFACE_SETUP = 8'h00;
	localparam logic [7:0] RST_RECORD_FILTER_PHASE_MUTE = 8'h00;
	// Whole bank of reset values, lowest index in the lowest byte.
	localparam logic [REG_COUNT-1:0][7:0] RST_BANK = {
		RST_RECORD_FILTER_PHASE_MUTE, RST_RECORD_INTERFACE_SETUP,
		RST_RECORD_LEVEL, RST_RECORD_LEVEL,
		RST_PLAYBACK_FILTER_ZERO_FLAGS, RST_PLAYBACK_RATE_PHASE_MUTE,
		RST_PLAYBACK_INTERFACE_SETUP, RST_PLAYBACK_LEVEL, RST_PLAYBACK_LEVEL,
		RST_POWER_AND_RESET_CONTROL};
	// Receiver states.
	typedef enum logic [2:0] {
		IMCP_IDLE = 3'b000,
		IMCP_ADDR = 3'b001,
		IMCP_ADDR_ACK = 3'b010,
		IMCP_INDEX = 3'b011,
		IMCP_INDEX_ACK = 3'b100,
		IMCP_DATA = 3'b101,
		IMCP_DATA_ACK = 3'b110,
		IMCP_IGNORE = 3'b111
	} imcp_state_t;
endpackage

// *** rtl/imcp_pin_sync.sv ***
// Three-stage pin synchroniser that accepts a change once the last two stages agree.
`timescale 1ns/100ps
module imcp_pin_sync
	import imcp_pkg::*;
#(
	parameter int WIDTH = 3,
	parameter logic [WIDTH-1:0] RESET_LEVEL = '1
)
(
	input wire logic clk_sys, // System clock.
	input wire logic rst, // Synchronous reset, active high.
	input wire logic [WIDTH-1:0] pin_in, // Asynchronous pin levels.
	output logic [WIDTH-1:0] level_out // Accepted levels.
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] level;
	} imcp_sync_t;

	imcp_sync_t sync_reg;
	imcp_sync_t sync_next;

	// The first stage feeds only the second; the agreement test looks at stages two and three,
	// which rejects a single-cycle glitch at the cost of one extra cycle of latency.
	always_comb
	begin
		sync_next.s1 = pin_in;
		sync_next.s2 = sync_reg.s1;
		sync_next.s3 = sync_reg.s2;
		sync_next.level = (~(sync_reg.s2 ^ sync_reg.s3) & sync_reg.s3)
			| ((sync_reg.s2 ^ sync_reg.s3) & sync_reg.level);
	end

	// State register with synchronous reset to the idle bus level.
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			sync_reg <= {RESET_LEVEL, RESET_LEVEL, RESET_LEVEL, RESET_LEVEL};
		end
		else
		begin
			sync_reg <= sync_next;
		end
	end

	assign level_out = sync_reg.level;
endmodule

// *** rtl/imcp_bus_events.sv ***
// Detector of start, stop and clock edges on the synchronised two-wire bus.
`timescale 1ns/100ps
module imcp_bus_events
	import imcp_pkg::*;
(
	input wire logic clk_sys, // System clock.
	input wire logic rst, // Synchronous reset, active high.
	input wire logic scl_level, // Synchronised clock line.
	input wire logic sda_level, // Synchronised data line.
	output logic start_seen, // Start or repeated start, one cycle.
	output logic stop_seen, // Stop, one cycle.
	output logic scl_rise, // Clock line rose, one cycle.
	output logic scl_fall // Clock line fell, one cycle.
);
	typedef struct packed {
		logic scl_prev;
		logic sda_prev;
	} imcp_edge_t;

	imcp_edge_t edge_reg;
	imcp_edge_t edge_next;

	// Previous levels; both lines idle high.
	always_comb
	begin
		edge_next.scl_prev = scl_level;
		edge_next.sda_prev = sda_level;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			edge_reg <= 2'b11;
		end
		else
		begin
			edge_reg <= edge_next;
		end
	end

	// A data change while the clock stays high is a bus condition, never a data bit.
	assign start_seen = scl_level & edge_reg.scl_prev & edge_reg.sda_prev & ~sda_level;
	assign stop_seen = scl_level & edge_reg.scl_prev & ~edge_reg.sda_prev & sda_level;
	assign scl_rise = scl_level & ~edge_reg.scl_prev;
	assign scl_fall = ~scl_level & edge_reg.scl_prev;
endmodule

// *** rtl/imcp_control_port.sv ***
// Two-wire mode control port: write-only bus slave and the ten mode control registers.
`timescale 1ns/100ps
module imcp_control_port
	import imcp_pkg::*;
(
	input wire logic clk_sys, // System clock, 125 MHz.
	input wire logic rst, // Synchronous reset, active high.
	input wire logic scl_in, // Bus clock line level.
	input wire logic sda_in, // Bus data line level.
	output logic sda_out, // Data line drive value, always low.
	output logic sda_oe, // High while pulling the data line low.
	input wire logic address_select_pin, // Low bit of the bus address.
	input wire logic port_select, // High hands the registers to the three-wire port.
	input wire logic alt_wr_en, // Three-wire port write strobe.
	input wire logic [7:0] alt_wr_index, // Three-wire port register index.
	input wire logic [7:0] alt_wr_data, // Three-wire port write data.
	output logic [7:0] power_and_reset_control, // Register 0x40.
	output logic [7:0] playback_level_first, // Register 0x41.
	output logic [7:0] playback_level_second, // Register 0x42.
	output logic [7:0] playback_interface_setup, // Register 0x43.
	output logic [7:0] playback_rate_phase_mute, // Register 0x44.
	output logic [7:0] playback_filter_zero_flags, // Register 0x45.
	output logic [7:0] record_level_first, // Register 0x46.
	output logic [7:0] record_level_second, // Register 0x47.
	output logic [7:0] record_interface_setup, // Register 0x48.
	output logic [7:0] record_filter_phase_mute, // Register 0x49.
	output logic register_reset_pulse, // Registers returned to defaults.
	output logic resync_pulse, // Converter resynchronisation request.
	output logic bus_selected // Device is addressed in the current transfer.
);
	// All receiver and register state in one packed record, registered in one place.
	typedef struct packed {
		imcp_state_t state;
		logic [7:0] shift;
		logic [3:0] bit_count;
		logic [7:0] index;
		logic ack_drive;
		logic [REG_COUNT-1:0][7:0] bank;
		logic reg_reset_pulse;
		logic resync_pulse;
	} imcp_ctrl_t;

	// Registered state and the next value that the single combinational block builds.
	imcp_ctrl_t ctrl_reg;
	imcp_ctrl_t ctrl_next;
	// Synchronised pin levels and the bus conditions derived from them.
	logic scl_level;
	logic sda_level;
	logic adr_level;
	logic start_seen;
	logic stop_seen;
	logic scl_rise;
	logic scl_fall;
	// Write request shared by both control ports, so the bank has exactly one write path.
	logic commit_en;
	logic [7:0] commit_idx;
	logic [7:0] commit_data;

	// True for an index inside the defined register window.
	// Used for the bus index byte, the running bus index and the three-wire port index.
	function automatic logic idx_valid(input logic [7:0] idx);
		idx_valid = (idx >= IDX_FIRST) && (idx <= IDX_LAST);
	endfunction

	// Next index after a received byte, wrapping at the end of the window.
	function automatic logic [7:0] idx_next(input logic [7:0] idx);
		logic [7:0] inc;
		inc = idx + 8'h01;
		idx_next = (inc == IDX_WRAP) ? IDX_FIRST : inc;
	endfunction

	// Bank slot of a valid index.
	// Callers check the index first, so only the low four bits of the difference can be set.
	function automatic logic [3:0] idx_slot(input logic [7:0] idx);
		logic [7:0] diff;
		diff = idx - IDX_FIRST;
		idx_slot = diff[3:0];
	endfunction

	// All three bus pins arrive from outside the clock domain.
	// The select pin shares the same latency and only matters at an address decision.
	imcp_pin_sync #(
		.WIDTH(3),
		.RESET_LEVEL(3'h7)
	) u_pin_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.pin_in({address_select_pin, sda_in, scl_in}),
		.level_out({adr_level, sda_level, scl_level})
	);

	// Oversampling at the system clock resolves both bus speeds with a wide margin.
	imcp_bus_events u_bus_events (
		.clk_sys(clk_sys),
		.rst(rst),
		.scl_level(scl_level),
		.sda_level(sda_level),
		.start_seen(start_seen),
		.stop_seen(stop_seen),
		.scl_rise(scl_rise),
		.scl_fall(scl_fall)
	);

	// Receiver sequencing and register commit. The master frames every transfer, so a stop
	// or a new start always returns the receiver to a known point, even mid-byte.
	always_comb
	begin
		ctrl_next = ctrl_reg;
		// Pulses fall by default, so each lasts exactly one cycle.
		ctrl_next.reg_reset_pulse = 1'b0;
		ctrl_next.resync_pulse = 1'b0;
		// The bus receiver is the default write source; the three-wire port overrides it below.
		commit_en = 1'b0;
		commit_idx = ctrl_reg.index;
		commit_data = ctrl_reg.shift;
		if (port_select)
		begin
			// The three-wire port owns the registers; the bus side stays silent.
			// Parking the receiver in idle means that handing the port back never resumes a stale transfer.
			ctrl_next.state = IMCP_IDLE;
			ctrl_next.ack_drive = 1'b0;
			commit_en = alt_wr_en && idx_valid(alt_wr_index);
			commit_idx = alt_wr_index;
			commit_data = alt_wr_data;
		end
		else if (stop_seen)
		begin
			// A byte cut short by a stop is dropped without any write.
			ctrl_next.state = IMCP_IDLE;
			ctrl_next.ack_drive = 1'b0;
		end
		else if (start_seen)
		begin
			// A repeated start abandons any byte in progress and listens for an address again.
			ctrl_next.state = IMCP_ADDR;
			ctrl_next.bit_count = 4'h0;
			ctrl_next.ack_drive = 1'b0;
		end
		else
		begin
			case (ctrl_reg.state)
				// Nothing on the bus concerns us until a start condition.
				IMCP_IDLE:
				begin
					ctrl_next.ack_drive = 1'b0;
				end

				// The three byte phases share one shifter; the state says what a complete byte means.
				// The decision falls on the clock fall after the eighth bit, so the acknowledge begins
				// while the clock is low and the master sees it settled before the ninth rising edge.
				IMCP_ADDR, IMCP_INDEX, IMCP_DATA:
				begin
					if (scl_rise && (ctrl_reg.bit_count < BYTE_BITS))
					begin
						// Most significant bit arrives first.
						ctrl_next.shift = {ctrl_reg.shift[6:0], sda_level};
						ctrl_next.bit_count = ctrl_reg.bit_count + 4'h1;
					end
					else if (scl_fall && (ctrl_reg.bit_count == BYTE_BITS))
					begin
						ctrl_next.bit_count = 4'h0;
						if (ctrl_reg.state == IMCP_ADDR)
						begin
							// Write direction only: a matching read address is not answered.
							if ((ctrl_reg.shift[7:2] == DEV_ADDR_HI)
								&& (ctrl_reg.shift[1] == adr_level)
								&& !ctrl_reg.shift[0])
							begin
								ctrl_next.state = IMCP_ADDR_ACK;
								ctrl_next.ack_drive = 1'b1;
							end
							else
							begin
								ctrl_next.state = IMCP_IGNORE;
							end
						end
						else if (ctrl_reg.state == IMCP_INDEX)
						begin
							// The index is kept even when refused; nothing is written through it before a new index.
							ctrl_next.index = ctrl_reg.shift;
							if (idx_valid(ctrl_reg.shift))
							begin
								ctrl_next.state = IMCP_INDEX_ACK;
								ctrl_next.ack_drive = 1'b1;
							end
							else
							begin
								ctrl_next.state = IMCP_IGNORE;
							end
						end
						// An accepted index never leaves the window, so this refusal only guards a corrupted index.
						else if (idx_valid(ctrl_reg.index))
						begin
							ctrl_next.state = IMCP_DATA_ACK;
							ctrl_next.ack_drive = 1'b1;
						end
						else
						begin
							ctrl_next.state = IMCP_IGNORE;
						end
					end
				end

				// Hold the acknowledge through the whole ninth clock and release it only once the clock
				// is low again, so the data line never moves while the clock is high.
				IMCP_ADDR_ACK:
				begin
					if (scl_fall)
					begin
						ctrl_next.state = IMCP_INDEX;
						ctrl_next.ack_drive = 1'b0;
					end
				end

				// Index acknowledged; the next byte is the first data byte.
				IMCP_INDEX_ACK:
				begin
					if (scl_fall)
					begin
						ctrl_next.state = IMCP_DATA;
						ctrl_next.ack_drive = 1'b0;
					end
				end

				// Commit on the rising clock of the acknowledge, then return for the next byte on its fall.
				IMCP_DATA_ACK:
				begin
					if (scl_rise)
					begin
						// The master has clocked the acknowledge: the byte is now final.
						commit_en = 1'b1;
						ctrl_next.index = idx_next(ctrl_reg.index);
					end
					else if (scl_fall)
					begin
						ctrl_next.state = IMCP_DATA;
						ctrl_next.ack_drive = 1'b0;
					end
				end

				// Not addressed or refused: keep off the bus until a stop or a new start.
				IMCP_IGNORE:
				begin
					ctrl_next.ack_drive = 1'b0;
				end

				// All eight 3-bit codes name a state; this branch only returns an unknown state value to idle rather than locking up the port.
				default:
				begin
					ctrl_next.state = IMCP_IDLE;
					ctrl_next.ack_drive = 1'b0;
				end
			endcase
		end
		// Register write path shared by both control ports.
		// Both sources check the index first, so no write outside the window gets this far.
		if (commit_en)
		begin
			if ((commit_idx == OFS_POWER_AND_RESET_CONTROL) && !commit_data[BIT_REGISTER_RESET])
			begin
				// Defaults reload the register reset bit as one, so it self-clears.
				ctrl_next.bank = RST_BANK;
				ctrl_next.reg_reset_pulse = 1'b1;
			end
			else if (commit_idx == OFS_POWER_AND_RESET_CONTROL)
			begin
				// Both reset bits always read back as one; the resync leaves the bank intact.
				ctrl_next.bank[idx_slot(commit_idx)] = commit_data
					| (8'h01 << BIT_REGISTER_RESET) | (8'h01 << BIT_RESYNC_RESET);
				ctrl_next.resync_pulse = !commit_data[BIT_RESYNC_RESET];
			end
			else
			begin
				ctrl_next.bank[idx_slot(commit_idx)] = commit_data;
			end
		end
	end

	// State register; the bank reset values carry every register default.
	// Shifter and counter are cleared too, although a start condition clears the counter and eight new bits fill the shifter before use.
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			ctrl_reg.state <= IMCP_IDLE;
			ctrl_reg.shift <= 8'h00;
			ctrl_reg.bit_count <= 4'h0;
			ctrl_reg.index <= IDX_FIRST;
			ctrl_reg.ack_drive <= 1'b0;
			ctrl_reg.bank <= RST_BANK;
			ctrl_reg.reg_reset_pulse <= 1'b0;
			ctrl_reg.resync_pulse <= 1'b0;
		end
		else
		begin
			ctrl_reg <= ctrl_next;
		end
	end

	// Open-drain data line: only ever pulled low, for an acknowledge.
	assign sda_out = 1'b0;
	assign sda_oe = ctrl_reg.ack_drive;
	assign register_reset_pulse = ctrl_reg.reg_reset_pulse;
	assign resync_pulse = ctrl_reg.resync_pulse;
	// Selected from our address acknowledge until the transfer ends or a byte is refused.
	assign bus_selected = (ctrl_reg.state != IMCP_IDLE) && (ctrl_reg.state != IMCP_ADDR)
		&& (ctrl_reg.state != IMCP_IGNORE);

	// Register contents, each byte at its own port.
	// Each port is a plain wire from a bank flop, so a register output never glitches.
	assign power_and_reset_control = ctrl_reg.bank[0];
	assign playback_level_first = ctrl_reg.bank[1];
	assign playback_level_second = ctrl_reg.bank[2];
	assign playback_interface_setup = ctrl_reg.bank[3];
	assign playback_rate_phase_mute = ctrl_reg.bank[4];
	assign playback_filter_zero_flags = ctrl_reg.bank[5];
	assign record_level_first = ctrl_reg.bank[6];
	assign record_level_second = ctrl_reg.bank[7];
	assign record_interface_setup = ctrl_reg.bank[8];
	assign record_filter_phase_mute = ctrl_reg.bank[9];
endmodule

// *** verification/imcp_control_port_props.sv ***
// Port-level checker of the two-wire mode control port.
`timescale 1ns/100ps
module imcp_control_port_props
	import imcp_pkg::*;
(
	input wire logic clk_sys, // System clock.
	input wire logic rst, // Synchronous reset.
	input wire logic sda_out, // Data drive value.
	input wire logic sda_oe, // Data drive enable.
	input wire logic port_select, // Three-wire port owns the registers.
	input wire logic alt_wr_en, // Three-wire write strobe.
	input wire logic [7:0] alt_wr_index, // Three-wire index.
	input wire logic [7:0] alt_wr_data, // Three-wire data.
	input wire logic [7:0] power_and_reset_control, // Register 0x40.
	input wire logic [7:0] playback_level_first, // Register 0x41.
	input wire logic [7:0] record_level_first, // Register 0x46.
	input wire logic register_reset_pulse, // Defaults restored.
	input wire logic resync_pulse, // Resynchronisation request.
	input wire logic bus_selected // Device addressed.
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Three-wire write aimed at the first playback level register.
	sequence alt_level_write;
		port_select && alt_wr_en && alt_wr_index == OFS_PLAYBACK_LEVEL_FIRST;
	endsequence
	// An acknowledge drive that has just begun.
	sequence ack_begins;
		$rose(sda_oe);
	endsequence
	drive_low_only_a: assert property (sda_oe |-> !sda_out) else $error("data line driven high");
	ack_when_selected_a: assert property (sda_oe |-> bus_selected || $past(bus_selected))
		else $error("acknowledge without selection");
	ack_holds_a: assert property (ack_begins |-> sda_oe[*8]) else $error("acknowledge too short");
	bus_silent_a: assert property (port_select[*8] |-> !sda_oe && !bus_selected)
		else $error("bus answered while handed over");
	alt_write_a: assert property (alt_level_write |=> playback_level_first == $past(alt_wr_data))
		else $error("three-wire write lost");
	reset_bits_high_a: assert property (power_and_reset_control[7:6] == 2'b11)
		else $error("reset bits not idle high");
	defaults_back_a: assert property (register_reset_pulse |-> power_and_reset_control == RST_POWER_AND_RESET_CONTROL
		&& playback_level_first == RST_PLAYBACK_LEVEL && record_level_first == RST_RECORD_LEVEL)
		else $error("defaults not restored");
	resync_alone_a: assert property (resync_pulse |-> !register_reset_pulse ##1 !resync_pulse)
		else $error("resync pulse malformed");
	reset_pulse_short_a: assert property (register_reset_pulse |=> !register_reset_pulse)
		else $error("reset pulse too long");
endmodule

bind imcp_control_port imcp_control_port_props u_props (.clk_sys, .rst, .sda_out, .sda_oe, .port_select,
	.alt_wr_en, .alt_wr_index, .alt_wr_data, .power_and_reset_control, .playback_level_first,
	.record_level_first, .register_reset_pulse, .resync_pulse, .bus_selected);

// *** verification/imcp_bus_master.sv ***
// Behavioural two-wire bus master that drives the control port's bus pins.
`timescale 1ns/100ps
module imcp_bus_master
	import imcp_pkg::*;
(
	input wire logic clk_sys, // System clock.
	input wire logic sda_line, // Resolved data line.
	output logic scl_line, // Clock line, high while idle.
	output logic sda_pull // High while pulling data low.
);
	// Idle bus: both lines released to their pull-ups.
	initial
	begin
		scl_line = 1'b1;
		sda_pull = 1'b0;
	end
	// Every pin change follows a rising edge of the system clock.
	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// Start: data falls while the clock line is high.
	task automatic start_cond();
		sda_pull <= 1'b1;
		wt(10);
		scl_line <= 1'b0;
	endtask
	// Stop: data rises while the clock line is high.
	task automatic stop_cond();
		wt(3);
		sda_pull <= 1'b1;
		wt(7);
		scl_line <= 1'b1;
		wt(10);
		sda_pull <= 1'b0;
		wt(20);
	endtask
	// Data moves three cycles after the clock falls, so it never changes while the clock is high.
	task automatic send(input logic [7:0] b, input int n, output logic ack);
		ack = 1'b0;
		for (int i = 0; i < n; i++)
		begin
			wt(3);
			sda_pull <= !b[7 - i];
			wt(7);
			scl_line <= 1'b1;
			wt(10);
			scl_line <= 1'b0;
		end
		if (n == 8)
		begin
			wt(3);
			sda_pull <= 1'b0;
			wt(7);
			scl_line <= 1'b1;
			wt(5);
			ack = !sda_line;
			wt(5);
			scl_line <= 1'b0;
		end
	endtask
endmodule

// *** verification/imcp_control_port_tb.sv ***
// Self-checking bench of the two-wire mode control port.
`timescale 1ns/100ps
module imcp_control_port_tb;
	import imcp_pkg::*;
	localparam logic [7:0] AW0 = {DEV_ADDR_HI, 2'b00};
	localparam logic [7:0] AW1 = {DEV_ADDR_HI, 2'b10};
	logic clk_sys, rst, scl_line, sda_pull, sda_line, sda_out, sda_oe, ack;
	logic adr_pin, port_select, alt_wr_en, reg_rst_p, resync_p, bus_selected;
	logic [7:0] alt_wr_index, alt_wr_data;
	logic [REG_COUNT-1:0][7:0] bank;
	logic [7:0] exp_bank [REG_COUNT];
	int n_errors, samples_checked, n_reg_rst, n_resync;
	// Open-drain line: pulled up unless some party pulls it low.
	assign sda_line = !sda_pull && !(sda_oe && !sda_out);
	imcp_control_port uut (.clk_sys(clk_sys), .rst(rst), .scl_in(scl_line), .sda_in(sda_line), .sda_out(sda_out),
		.sda_oe(sda_oe), .address_select_pin(adr_pin), .port_select(port_select), .alt_wr_en(alt_wr_en),
		.alt_wr_index(alt_wr_index), .alt_wr_data(alt_wr_data), .power_and_reset_control(bank[0]),
		.playback_level_first(bank[1]), .playback_level_second(bank[2]), .playback_interface_setup(bank[3]),
		.playback_rate_phase_mute(bank[4]), .playback_filter_zero_flags(bank[5]), .record_level_first(bank[6]),
		.record_level_second(bank[7]), .record_interface_setup(bank[8]), .record_filter_phase_mute(bank[9]),
		.register_reset_pulse(reg_rst_p), .resync_pulse(resync_p), .bus_selected(bus_selected));
	imcp_bus_master u_master (.clk_sys(clk_sys), .sda_line(sda_line), .scl_line(scl_line), .sda_pull(sda_pull));
	// Clock of 8 ns.
	initial
	begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	// Pulse counters, so short pulses are never missed between checks.
	always @(posedge clk_sys)
	begin
		if (reg_rst_p === 1'b1)
			n_reg_rst++;
		if (resync_p === 1'b1)
			n_resync++;
	end
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] want);
		samples_checked++;
		if (got !== want)
		begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, want);
		end
	endtask
	task automatic check_bank();
		for (int i = 0; i < REG_COUNT; i++)
			chk(bank[i], exp_bank[i]);
	endtask
	task automatic defaults();
		for (int i = 0; i < REG_COUNT; i++)
			exp_bank[i] = RST_BANK[i];
	endtask
	// One whole write frame; the first n_ack bytes must be acknowledged, the rest not.
	task automatic frame(input logic [7:0] b[$], input int n_ack);
		u_master.start_cond();
		foreach (b[i])
		begin
			u_master.send(b[i], 8, ack);
			chk({7'h00, ack}, {7'h00, i < n_ack});
		end
		u_master.stop_cond();
	endtask
	// Three-wire write strobe of one cycle.
	task automatic alt_wr(input logic [7:0] idx, input logic [7:0] d);
		@(posedge clk_sys);
		alt_wr_index <= idx;
		alt_wr_data <= d;
		alt_wr_en <= 1'b1;
		@(posedge clk_sys);
		alt_wr_en <= 1'b0;
	endtask
	// Watchdog sized well above the roughly 6200 cycles the tests need.
	initial
	begin
		repeat (60000) @(posedge clk_sys);
		n_errors++;
		$display("watchdog expired");
		end_sim();
	end
	initial
	begin
		rst = 1'b1;
		adr_pin = 1'b0;
		port_select = 1'b0;
		alt_wr_en = 1'b0;
		alt_wr_index = 8'h00;
		alt_wr_data = 8'h00;
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		u_master.wt(8);
		defaults();
		check_bank();
		$display("test defaults done");
		frame('{AW0, OFS_PLAYBACK_LEVEL_FIRST, 8'ha5}, 3);
		exp_bank[1] = 8'ha5;
		check_bank();
		$display("test single write done");
		frame('{AW0, OFS_RECORD_INTERFACE_SETUP, 8'h11, 8'h22, 8'hc1, 8'h3c}, 6);
		exp_bank[8] = 8'h11;
		exp_bank[9] = 8'h22;
		exp_bank[0] = 8'hc1;
		exp_bank[1] = 8'h3c;
		check_bank();
		$display("test wrap done");
		frame('{AW1, OFS_PLAYBACK_LEVEL_SECOND, 8'h00}, 0);
		frame('{AW0 | 8'h01, 8'h00}, 0);
		frame('{AW0, IDX_WRAP, 8'h00}, 1);
		u_master.start_cond();
		u_master.send(AW0, 8, ack);
		chk({7'h00, ack}, 8'h01);
		u_master.send(OFS_PLAYBACK_LEVEL_SECOND, 8, ack);
		chk({7'h00, ack}, 8'h01);
		chk({7'h00, bus_selected}, 8'h01);
		u_master.send(8'h00, 4, ack);
		u_master.stop_cond();
		chk({7'h00, bus_selected}, 8'h00);
		check_bank();
		$display("test refusals done");
		adr_pin <= 1'b1;
		u_master.wt(8);
		frame('{AW1, OFS_RECORD_LEVEL_SECOND, 8'h5a}, 3);
		exp_bank[7] = 8'h5a;
		frame('{AW1, OFS_POWER_AND_RESET_CONTROL, 8'h81}, 3);
		exp_bank[0] = 8'hc1;
		check_bank();
		chk(8'(n_resync), 8'h01);
		$display("test resync done");
		frame('{AW1, OFS_POWER_AND_RESET_CONTROL, 8'h30}, 3);
		defaults();
		check_bank();
		chk(8'(n_reg_rst), 8'h01);
		chk(8'(n_resync), 8'h01);
		$display("test register reset done");
		port_select <= 1'b1;
		u_master.wt(10);
		frame('{AW1, OFS_PLAYBACK_LEVEL_FIRST, 8'h12}, 0);
		alt_wr(OFS_RECORD_LEVEL_FIRST, 8'h3c);
		alt_wr(OFS_PLAYBACK_LEVEL_FIRST, 8'h77);
		alt_wr(IDX_WRAP, 8'h01);
		exp_bank[6] = 8'h3c;
		exp_bank[1] = 8'h77;
		u_master.wt(2);
		check_bank();
		port_select <= 1'b0;
		$display("test three-wire port done");
		end_sim();
	end
endmodule
